// ===== cism_assertions.sv
module cism_assertions (
	input wire        i_ref_clk,               // Clock
	input wire        i_reset_n,               // Reset, active low
	input wire [11:0] i_addr,                  // Address
	input wire        i_wr,                    // Write strobe
	input wire        i_rd,                    // Read strobe
	input wire [31:0] i_wdata,                 // Write data
	input wire [31:0] o_rdata,                 // Read data
	input wire        o_rvalid,                // Read valid
	input wire        o_inta_n,                // Interrupt, active low
	input wire        o_chipset_compat_enable, // Compat bit
	input wire        i_program_enable,        // Program enable
	input wire        o_program_enable_clr,    // Enable clear pulse
	input wire        i_parity_resp_en,        // Parity response
	input wire [31:0] i_start_address,         // Start address
	input wire        i_fetch_parity_err,      // Fetch parity error
	input wire        i_bus_parity_err         // Bus parity error
);
	timeunit 1ns;
	timeprecision 1ns;
	// Shadow of the mask so interrupt timing can be judged from the ports alone
	reg [22:0] mask;
	always @(posedge i_ref_clk or negedge i_reset_n)
		if (!i_reset_n)
			mask <= 23'h0;
		else if (i_wr && i_addr == 12'h104)
			mask <= i_wdata[22:0];
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	sequence s_load;
		$rose(i_program_enable);
	endsequence
	sequence s_ptr_read;
		i_rd && i_addr == 12'h120;
	endsequence
	a_ptr_load: assert property (s_load ##1 s_ptr_read |=> o_rdata == $past(i_start_address, 2))
		else $error("pointer not loaded from start address");
	a_read_answer: assert property (i_rd |=> o_rvalid)
		else $error("read not answered next cycle");
	a_running_bit: assert property (i_rd && i_addr == 12'h100 |=> o_rdata[27] == $past(i_program_enable))
		else $error("running bit differs from enable");
	a_reserved_zero: assert property (i_rd && i_addr == 12'h100 |=> o_rdata[26] == 1'b0 && o_rdata[23:20] == 4'h0
		&& o_rdata[10] == 1'b0 && o_rdata[7:6] == 2'h0)
		else $error("reserved status bits not zero");
	a_unmapped_zero: assert property (i_rd && i_addr != 12'h100 && i_addr != 12'h104 && i_addr != 12'h120
		|=> o_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_parity_stop: assert property (i_fetch_parity_err && i_parity_resp_en |-> o_program_enable_clr)
		else $error("program enable not cleared");
	a_compat_bit: assert property (i_wr && i_addr == 12'h104 |=> o_chipset_compat_enable == $past(i_wdata[23]))
		else $error("compat bit not written");
	a_irq_masked: assert property (mask == 23'h0 |-> o_inta_n)
		else $error("interrupt with all masked");
	a_parity_irq: assert property (i_bus_parity_err && mask[15] && !(i_wr && i_addr == 12'h104) |=> !o_inta_n)
		else $error("parity event raised no interrupt");
	a_level_hold: assert property (!o_inta_n && !i_wr |=> !o_inta_n)
		else $error("interrupt released without a write");
	a_no_fetch_stop: assert property (!i_parity_resp_en |-> !o_program_enable_clr)
		else $error("program enable cleared with response off");
endmodule // cism_assertions

// ===== cism_core.v
`include "cism_regs.vh"

// Behaviour
// R1 - Writing one to a clearable status bit clears it; zeros leave it alone.
// R2 - Four-bit program status set/cleared by instruction set and reset bits.
// R3 - Program-running bit reads zero while DMA is disabled; no interrupt.
// R4 - Ack bit set on successful serial op, cleared at done if unacknowledged.
// R5 - Field bit reads 0 for odd field, 1 for even; status only.
// R6 - Sync error flag set on sync counter overflow or sync code mismatch.
// R7 - Opcode error flag set on any decoded instruction error.
// R8 - Bus abort flag set on master or target abort as initiator.
// R9 - Fetch parity error with response on sets flag and stops DMA.
// R10 - General parity flag set on any bus parity error, always.
// R11 - Resync flag set when FIFO stream disagrees with program expectations.
// R12 - Target latency flag set when overrun ends a slow-target transaction.
// R13 - Bus latency flag set when overrun drops words due to slow bus.
// R14 - Program interrupt flag set by executed instruction with IRQ bit.
// R15 - General purpose flag set on programmed edge or level of pin.
// R16 - Serial completion flag set when a serial operation finishes.
// R17 - Presence flag on video present toggle; lock flag on lock change.
// R18 - Overflow flag on converter overflow; format flag on standard switch.
// R19 - Line flag on new line or reset edge; field flag on field change.
// R20 - Low 23 mask bits enable matching status bits; pending unmask fires at once.
// R21 - INTA is a level held until pending enabled conditions are cleared or masked.
// R22 - Read-only program counter register returns the DMA instruction pointer.
// R23 - Pointer loads start address on rising edge of program enable.
// R24 - Interrupt is OR of pending-and-enabled bits; status-only bits excluded.
module cism_core (
	input  wire        i_ref_clk,            // 40 MHz register clock
	input  wire        i_reset_n,            // Async reset, active low
	input  wire [11:0] i_addr,               // Register byte address
	input  wire        i_wr,                 // Write strobe, one cycle
	input  wire        i_rd,                 // Read strobe, one cycle
	input  wire [31:0] i_wdata,              // Write data
	output reg  [31:0] o_rdata,              // Read data, registered
	output reg         o_rvalid,             // Read data valid pulse
	output wire        o_inta_n,             // Interrupt request, active low level
	output wire        o_chipset_compat_enable, // Compatibility mode bit
	input  wire        i_program_enable,     // DMA program enable from control reg
	output wire        o_program_enable_clr, // Pulse: clear program enable
	input  wire        i_parity_resp_en,     // Parity error response enable
	input  wire [31:0] i_start_address,      // Program start address
	input  wire        i_instr_advance,      // Instruction fetched, bump pointer
	input  wire        i_instr_exec,         // Instruction executed pulse
	input  wire [3:0]  i_instr_status_set,   // Status set bits of instruction
	input  wire [3:0]  i_instr_status_reset, // Status reset bits of instruction
	input  wire        i_instr_irq,          // IRQ bit of instruction
	input  wire        i_sync_overflow,      // End-of-line sync counter overflow
	input  wire        i_sync_mismatch,      // Sync codes disagree
	input  wire        i_opcode_error,       // Instruction decode error
	input  wire        i_master_abort,       // Master abort received
	input  wire        i_target_abort,       // Target abort received
	input  wire        i_fetch_parity_err,   // Data parity error on fetch
	input  wire        i_bus_parity_err,     // Any bus parity error
	input  wire        i_stream_resync,      // FIFO stream resync event
	input  wire        i_overrun_target,     // Overrun, slow target terminated
	input  wire        i_overrun_drop,       // Overrun, words dropped
	input  wire        i_serial_done,        // Serial operation finished
	input  wire        i_serial_acked,       // Serial receiver acknowledged
	input  wire        i_external_interrupt_pin, // Async general purpose pin
	input  wire        i_gp_invert,          // Invert the pin
	input  wire        i_gp_edge_mode,       // 1: rising edge, 0: level
	input  wire        i_video_present,      // Async video present level
	input  wire        i_horizontal_lock,    // Async horizontal lock level
	input  wire        i_converter_overflow, // Converter overflow pulse
	input  wire        i_format_pal,         // Async input standard level
	input  wire        i_new_line,           // New analog line pulse
	input  wire        i_horizontal_reset_input, // Async external horizontal reset
	input  wire        i_even_field          // Async field level, 1 = even
);
	localparam NEV = 23;

	wire        wr_status  = i_wr && (i_addr == `CISM_OFS_STATUS);
	wire        wr_mask    = i_wr && (i_addr == `CISM_OFS_MASK);

	// Pin and video levels arrive from other domains
	wire [5:0] sync_lv;
	cism_sync2 #(.WIDTH(6)) u_sync (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_async   ({i_external_interrupt_pin, i_video_present, i_horizontal_lock,
			i_format_pal, i_horizontal_reset_input, i_even_field}),
		.o_sync    (sync_lv)
	);
	wire gp_lvl    = sync_lv[5] ^ i_gp_invert;
	wire field_lvl = sync_lv[0];

	reg [5:0] prev_lv;
	reg       prev_gp;
	reg       program_prev;
	always @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prev_lv      <= 6'h00;
			prev_gp      <= 1'b0;
			program_prev <= 1'b0;
		end else begin
			prev_lv      <= sync_lv;
			prev_gp      <= gp_lvl;
			program_prev <= i_program_enable;
		end
	end
	wire [5:0] lv_chg = sync_lv ^ prev_lv;

	// Event sources per status bit
	reg [NEV-1:0] ev_set;
	always @* begin
		ev_set = {NEV{1'b0}};
		ev_set[`CISM_SYNC_ERR_BIT]   = i_sync_overflow | i_sync_mismatch; // R6
		ev_set[`CISM_OPCODE_ERR_BIT] = i_opcode_error; // R7
		ev_set[`CISM_ABORT_BIT]      = i_master_abort | i_target_abort; // R8
		ev_set[`CISM_INSTR_PAR_BIT]  = i_fetch_parity_err & i_parity_resp_en; // R9
		ev_set[`CISM_GEN_PAR_BIT]    = i_bus_parity_err; // R10
		ev_set[`CISM_RESYNC_BIT]     = i_stream_resync; // R11
		ev_set[`CISM_TGT_LAT_BIT]    = i_overrun_target; // R12
		ev_set[`CISM_BUS_LAT_BIT]    = i_overrun_drop; // R13
		ev_set[`CISM_PROG_IRQ_BIT]   = i_instr_exec & i_instr_irq; // R14
		// Level mode keeps setting while the pin is active
		ev_set[`CISM_GP_IRQ_BIT]     = i_gp_edge_mode ? (gp_lvl & ~prev_gp) : gp_lvl; // R15
		ev_set[`CISM_SER_DONE_BIT]   = i_serial_done; // R16
		ev_set[`CISM_PRESENCE_BIT]   = lv_chg[4]; // R17
		ev_set[`CISM_LOCK_BIT]       = lv_chg[3]; // R17
		ev_set[`CISM_OVERFLOW_BIT]   = i_converter_overflow; // R18
		ev_set[`CISM_FORMAT_BIT]     = lv_chg[2]; // R18
		ev_set[`CISM_LINE_BIT]       = i_new_line | (sync_lv[1] & ~prev_lv[1]); // R19
		ev_set[`CISM_FIELDCHG_BIT]   = lv_chg[0]; // R19
	end

	wire [NEV-1:0] ev_flag;
	wire [NEV-1:0] ev_clr = (wr_status ? i_wdata[NEV-1:0] : {NEV{1'b0}}) & `CISM_EVENT_MASK; // R1
	// Reserved positions hold zero so a mask bit there can never raise the request
	assign ev_flag[22:20] = 3'h0;
	assign ev_flag[10]    = 1'b0;
	assign ev_flag[7:6]   = 2'h0;

	cism_event_flag u_sync_err (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_set     (ev_set[`CISM_SYNC_ERR_BIT]),
		.i_clear   (ev_clr[`CISM_SYNC_ERR_BIT]),
		.o_flag    (ev_flag[`CISM_SYNC_ERR_BIT])
	);
	cism_event_flag u_opcode_err (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_set     (ev_set[`CISM_OPCODE_ERR_BIT]),
		.i_clear   (ev_clr[`CISM_OPCODE_ERR_BIT]),
		.o_flag    (ev_flag[`CISM_OPCODE_ERR_BIT])
	);
	cism_event_flag u_abort (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_set     (ev_set[`CISM_ABORT_BIT]),
		.i_clear   (ev_clr[`CISM_ABORT_BIT]),
		.o_flag    (ev_flag[`CISM_ABORT_BIT])
	);
	cism_event_flag u_instr_par (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_set     (ev_set[`CISM_INSTR_PAR_BIT]),
		.i_clear   (ev_clr[`CISM_INSTR_PAR_BIT]),
		.o_flag    (ev_flag[`CISM_INSTR_PAR_BIT])
	);
	cism_event_flag u_gen_par (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_set     (ev_set[`CISM_GEN_PAR_BIT]),
		.i_clear   (ev_clr[`CISM_GEN_PAR_BIT]),
		.o_flag    (ev_flag[`CISM_GEN_PAR_BIT])
	);
	cism_event_flag u_resync (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_set     (ev_set[`CISM_RESYNC_BIT]),
		.i_clear   (ev_clr[`CISM_RESYNC_BIT]),
		.o_flag    (ev_flag[`CISM_RESYNC_BIT])
	);
	cism_event_flag u_tgt_lat (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_set     (ev_set[`CISM_TGT_LAT_BIT]),
		.i_clear   (ev_clr[`CISM_TGT_LAT_BIT]),
		.o_flag    (ev_flag[`CISM_TGT_LAT_BIT])
	);
	cism_event_flag u_bus_lat (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_set     (ev_set[`CISM_BUS_LAT_BIT]),
		.i_clear   (ev_clr[`CISM_BUS_LAT_BIT]),
		.o_flag    (ev_flag[`CISM_BUS_LAT_BIT])
	);
	cism_event_flag u_prog_irq (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_set     (ev_set[`CISM_PROG_IRQ_BIT]),
		.i_clear   (ev_clr[`CISM_PROG_IRQ_BIT]),
		.o_flag    (ev_flag[`CISM_PROG_IRQ_BIT])
	);
	cism_event_flag u_gp_irq (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_set     (ev_set[`CISM_GP_IRQ_BIT]),
		.i_clear   (ev_clr[`CISM_GP_IRQ_BIT]),
		.o_flag    (ev_flag[`CISM_GP_IRQ_BIT])
	);
	cism_event_flag u_ser_done (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_set     (ev_set[`CISM_SER_DONE_BIT]),
		.i_clear   (ev_clr[`CISM_SER_DONE_BIT]),
		.o_flag    (ev_flag[`CISM_SER_DONE_BIT])
	);
	cism_event_flag u_presence (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_set     (ev_set[`CISM_PRESENCE_BIT]),
		.i_clear   (ev_clr[`CISM_PRESENCE_BIT]),
		.o_flag    (ev_flag[`CISM_PRESENCE_BIT])
	);
	cism_event_flag u_lock (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_set     (ev_set[`CISM_LOCK_BIT]),
		.i_clear   (ev_clr[`CISM_LOCK_BIT]),
		.o_flag    (ev_flag[`CISM_LOCK_BIT])
	);
	cism_event_flag u_overflow (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_set     (ev_set[`CISM_OVERFLOW_BIT]),
		.i_clear   (ev_clr[`CISM_OVERFLOW_BIT]),
		.o_flag    (ev_flag[`CISM_OVERFLOW_BIT])
	);
	cism_event_flag u_line (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_set     (ev_set[`CISM_LINE_BIT]),
		.i_clear   (ev_clr[`CISM_LINE_BIT]),
		.o_flag    (ev_flag[`CISM_LINE_BIT])
	);
	cism_event_flag u_fieldchg (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_set     (ev_set[`CISM_FIELDCHG_BIT]),
		.i_clear   (ev_clr[`CISM_FIELDCHG_BIT]),
		.o_flag    (ev_flag[`CISM_FIELDCHG_BIT])
	);
	cism_event_flag u_format (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_set     (ev_set[`CISM_FORMAT_BIT]),
		.i_clear   (ev_clr[`CISM_FORMAT_BIT]),
		.o_flag    (ev_flag[`CISM_FORMAT_BIT])
	);

	// Status-only bits, which writes do not touch, plus the written mask and the pointer
	reg [3:0]  prog_status;
	reg        serial_ack;
	reg [`CISM_MASK_WIDTH-1:0] mask;
	reg [31:0] pointer;
	always @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prog_status <= 4'h0;
			serial_ack  <= 1'b0;
			mask        <= `CISM_MASK_RESET;
			pointer     <= `CISM_PTR_RESET;
		end else begin
			if (i_instr_exec)
				prog_status <= (prog_status | i_instr_status_set) & ~i_instr_status_reset; // R2
			if (i_serial_done)
				serial_ack <= i_serial_acked; // R4
			if (wr_mask)
				mask <= i_wdata[`CISM_MASK_WIDTH-1:0];
			if (i_program_enable && !program_prev)
				pointer <= i_start_address; // R23
			else if (i_instr_advance)
				pointer <= pointer + 32'h00000004; // R22
		end
	end

	assign o_program_enable_clr = ev_set[`CISM_INSTR_PAR_BIT]; // R9
	assign o_chipset_compat_enable = mask[`CISM_COMPAT_BIT];

	wire [31:0] status_word = {prog_status, // R2
		i_program_enable, // R3
		1'b0, serial_ack, field_lvl, // R4 R5
		1'b0, 1'b0, 1'b0, 1'b0, ev_flag[19:0]};

	// Only event flags feed the request, so status-only bits cannot assert it
	wire irq = |(ev_flag & mask[NEV-1:0]); // R20 R24
	assign o_inta_n = ~irq; // R21

	always @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata  <= 32'h00000000;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_rd;
			if (i_rd) begin
				case (i_addr)
					`CISM_OFS_STATUS:  o_rdata <= status_word;
					`CISM_OFS_MASK:    o_rdata <= {8'h00, mask};
					`CISM_OFS_POINTER: o_rdata <= pointer; // R22
					default:           o_rdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // cism_core

// ===== cism_event_flag.v
// Sticky flag; a set in the same cycle as a clear wins
module cism_event_flag (
	input  wire i_ref_clk,   // Clock
	input  wire i_reset_n,   // Async reset, active low
	input  wire i_set,       // Event pulse
	input  wire i_clear,     // Write-one-to-clear strobe
	output reg  o_flag       // Sticky flag
);
	always @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			o_flag <= 1'b0;
		else if (i_set)
			o_flag <= 1'b1;
		else if (i_clear)
			o_flag <= 1'b0;
	end
endmodule // cism_event_flag

// ===== cism_host.sv
module cism_host (
	input  wire        i_ref_clk, // Clock
	output reg  [11:0] o_addr,    // Address
	output reg         o_wr,      // Write strobe
	output reg         o_rd,      // Read strobe
	output reg  [31:0] o_wdata,   // Write data
	input  wire [31:0] i_rdata,   // Read data
	input  wire        i_rvalid   // Read valid
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
		{o_addr, o_wr, o_rd, o_wdata} = 46'h0;
	// Released lines show inverted values so stale data cannot pass as valid
	task wr(input [11:0] a, input [31:0] d);
		@(negedge i_ref_clk);
		{o_addr, o_wdata, o_wr} = {a, d, 1'b1};
		@(negedge i_ref_clk);
		{o_addr, o_wdata, o_wr} = {~a, ~d, 1'b0};
	endtask
	task rd(input [11:0] a, output [31:0] d);
		@(negedge i_ref_clk);
		{o_addr, o_rd} = {a, 1'b1};
		@(negedge i_ref_clk);
		{o_addr, o_rd} = {~a, 1'b0};
		d = i_rvalid ? i_rdata : ~i_rdata;
	endtask
	task clr(output [31:0] d);
		rd(12'h100, d);
		wr(12'h100, d);
	endtask
endmodule // cism_host

// ===== cism_regs.vh
`ifndef CISM_REGS_VH
`define CISM_REGS_VH
// Register byte offsets
`define CISM_OFS_STATUS      12'h100
`define CISM_OFS_MASK        12'h104
`define CISM_OFS_POINTER     12'h120
// Status field positions
`define CISM_PROG_STATUS_HI  31
`define CISM_PROG_STATUS_LO  28
`define CISM_RUNNING_BIT     27
`define CISM_ACK_BIT         25
`define CISM_FIELD_BIT       24
`define CISM_SYNC_ERR_BIT    19
`define CISM_OPCODE_ERR_BIT  18
`define CISM_ABORT_BIT       17
`define CISM_INSTR_PAR_BIT   16
`define CISM_GEN_PAR_BIT     15
`define CISM_RESYNC_BIT      14
`define CISM_TGT_LAT_BIT     13
`define CISM_BUS_LAT_BIT     12
`define CISM_PROG_IRQ_BIT    11
`define CISM_GP_IRQ_BIT      9
`define CISM_SER_DONE_BIT    8
`define CISM_PRESENCE_BIT    5
`define CISM_LOCK_BIT        4
`define CISM_OVERFLOW_BIT    3
`define CISM_LINE_BIT        2
`define CISM_FIELDCHG_BIT    1
`define CISM_FORMAT_BIT      0
// Event flag positions that can be cleared and masked
`define CISM_EVENT_MASK      23'h0ffb3f
`define CISM_MASK_WIDTH      24
`define CISM_MASK_RESET      24'h000000
`define CISM_COMPAT_BIT      23
`define CISM_PTR_RESET       32'h00000000
`endif

// ===== cism_sync2.v
module cism_sync2 #(
	parameter WIDTH = 1
) (
	input  wire             i_ref_clk,   // Clock
	input  wire             i_reset_n,   // Async reset, active low
	input  wire [WIDTH-1:0] i_async,     // Input from another domain
	output wire [WIDTH-1:0] o_sync       // Synchronised level
);
	reg [WIDTH-1:0] stage1;
	reg [WIDTH-1:0] stage2;

	always @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			stage1 <= {WIDTH{1'b0}};
			stage2 <= {WIDTH{1'b0}};
		end else begin
			stage1 <= i_async;
			stage2 <= stage1;
		end
	end

	assign o_sync = stage2;
endmodule // cism_sync2

// ===== testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	reg        ref_clk = 1'b0;
	reg        reset_n = 1'b0;
	reg [12:0] pulse = 13'h0;
	reg [5:0]  lvl = 6'h0;
	reg        pe = 1'b0, adv = 1'b0, exec = 1'b0, irq = 1'b0, acked = 1'b0;
	reg        resp = 1'b1, gp_inv = 1'b0, gp_edge = 1'b1;
	reg [3:0]  sset = 4'h0, srst = 4'h0;
	reg [31:0] start = 32'h0, v;
	wire [11:0] addr;
	wire        wr, rd, rvalid, inta_n, compat, pe_clr;
	wire [31:0] wdata, rdata;
	integer    fail_count = 0, compares = 0, i;
	int        rows [19][2] = '{'{0,19},'{1,19},'{2,18},'{3,17},'{4,17},'{5,16},'{6,15},'{7,14},'{8,13},'{9,12},
		'{10,8},'{11,3},'{12,2},'{13,9},'{14,5},'{15,4},'{16,0},'{17,2},'{18,1}};
	always #12.5 ref_clk = ~ref_clk;
	cism_host host (.i_ref_clk(ref_clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata), .i_rdata(rdata),
		.i_rvalid(rvalid));
	cism_core dut (.i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata),
		.o_rdata(rdata), .o_rvalid(rvalid), .o_inta_n(inta_n), .o_chipset_compat_enable(compat),
		.i_program_enable(pe), .o_program_enable_clr(pe_clr), .i_parity_resp_en(resp), .i_start_address(start),
		.i_instr_advance(adv), .i_instr_exec(exec), .i_instr_status_set(sset), .i_instr_status_reset(srst),
		.i_instr_irq(irq), .i_sync_overflow(pulse[0]), .i_sync_mismatch(pulse[1]), .i_opcode_error(pulse[2]),
		.i_master_abort(pulse[3]), .i_target_abort(pulse[4]), .i_fetch_parity_err(pulse[5]),
		.i_bus_parity_err(pulse[6]), .i_stream_resync(pulse[7]), .i_overrun_target(pulse[8]),
		.i_overrun_drop(pulse[9]), .i_serial_done(pulse[10]), .i_serial_acked(acked),
		.i_converter_overflow(pulse[11]), .i_new_line(pulse[12]), .i_external_interrupt_pin(lvl[0]),
		.i_gp_invert(gp_inv), .i_gp_edge_mode(gp_edge), .i_video_present(lvl[1]), .i_horizontal_lock(lvl[2]),
		.i_format_pal(lvl[3]), .i_horizontal_reset_input(lvl[4]), .i_even_field(lvl[5]));
	task chk(input string n, input [31:0] e, input [31:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// Async levels need three edges to land, so every event waits five cycles
	task fire(input int k);
		@(negedge ref_clk);
		if (k < 13)
			pulse = 13'h1 << k;
		else
			lvl = lvl ^ (6'h1 << (k - 13));
		@(negedge ref_clk);
		pulse = 13'h0;
		repeat (4) @(negedge ref_clk);
	endtask
	task summarize;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#100000;
		fail_count++;
		summarize;
	end
	initial begin
		repeat (20) @(negedge ref_clk);
		reset_n = 1'b1;
		host.rd(12'h104, v);
		chk("mask reset", 32'h0, v);
		host.rd(12'h120, v);
		chk("pointer reset", 32'h0, v);
		host.rd(12'h100, v);
		chk("status reset", 32'h0, v);
		$display("test reset done");
		host.wr(12'h104, 32'h007fffff);
		for (i = 0; i < 19; i++) begin
			fire(rows[i][0]);
			host.rd(12'h100, v);
			chk("flag", (32'h1 << rows[i][1]) | {7'h0, lvl[5], 24'h0}, v);
			chk("inta asserted", 32'h0, {31'h0, inta_n});
			host.wr(12'h100, v);
			host.rd(12'h100, v);
			chk("flag cleared", {7'h0, lvl[5], 24'h0}, v);
			chk("inta released", 32'h1, {31'h0, inta_n});
		end
		$display("test events done");
		acked = 1'b1;
		fire(10);
		host.clr(v);
		chk("ack set", 32'h03000100, v);
		acked = 1'b0;
		fire(10);
		host.clr(v);
		chk("ack cleared", 32'h01000100, v);
		@(negedge ref_clk);
		{exec, sset, irq} = {1'b1, 4'ha, 1'b1};
		@(negedge ref_clk);
		{sset, srst, irq} = {4'h0, 4'h8, 1'b0};
		@(negedge ref_clk);
		{exec, srst} = 5'h0;
		host.clr(v);
		chk("program status", 32'h21000800, v);
		host.rd(12'h100, v);
		chk("status kept", 32'h21000000, v);
		$display("test program done");
		host.wr(12'h104, 32'h0);
		fire(6);
		chk("masked pending", 32'h1, {31'h0, inta_n});
		host.wr(12'h104, 32'h00808000);
		chk("unmask fires", 32'h0, {31'h0, inta_n});
		chk("compat bit", 32'h1, {31'h0, compat});
		host.clr(v);
		chk("cleared irq", 32'h1, {31'h0, inta_n});
		start = 32'h00001000;
		pe = 1'b1;
		host.rd(12'h120, v);
		chk("pointer load", 32'h00001000, v);
		@(negedge ref_clk);
		adv = 1'b1;
		repeat (2) @(negedge ref_clk);
		adv = 1'b0;
		host.wr(12'h120, 32'hffffffff);
		host.rd(12'h120, v);
		chk("pointer advance", 32'h00001008, v);
		host.rd(12'h100, v);
		chk("running bit", 32'h29000000, v);
		host.rd(12'h108, v);
		chk("unmapped", 32'h0, v);
		$display("test pointer done");
		gp_edge = 1'b0;
		host.clr(v);
		host.rd(12'h100, v);
		chk("gp level", 32'h29000200, v);
		gp_inv = 1'b1;
		host.clr(v);
		host.rd(12'h100, v);
		chk("gp inverted", 32'h29000000, v);
		resp = 1'b0;
		@(negedge ref_clk);
		pulse = 13'h20;
		@(posedge ref_clk);
		chk("stop off", 32'h0, {31'h0, pe_clr});
		@(negedge ref_clk);
		{resp, pulse} = 14'h2000;
		host.rd(12'h100, v);
		chk("no fetch flag", 32'h29000000, v);
		@(negedge ref_clk);
		pulse = 13'h20;
		@(posedge ref_clk);
		chk("stop on", 32'h1, {31'h0, pe_clr});
		@(negedge ref_clk);
		pulse = 13'h0;
		host.clr(v);
		chk("fetch flag", 32'h29010000, v);
		fork
			host.wr(12'h100, 32'h00008000);
			fire(6);
		join
		host.clr(v);
		chk("set wins", 32'h29008000, v);
		{pe, gp_inv, gp_edge} = 3'b001;
		@(negedge ref_clk);
		reset_n = 1'b0;
		@(negedge ref_clk);
		chk("reset outputs", 32'h1, {29'h0, rvalid, compat, inta_n});
		reset_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		host.rd(12'h100, v);
		chk("levels after reset", 32'h01000237, v);
		host.rd(12'h104, v);
		chk("mask after reset", 32'h0, v);
		$display("test awkward done");
		summarize;
	end
endmodule // testbench
bind cism_core cism_assertions chk (.i_ref_clk, .i_reset_n, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata, .o_rvalid,
	.o_inta_n, .o_chipset_compat_enable, .i_program_enable, .o_program_enable_clr, .i_parity_resp_en,
	.i_start_address, .i_fetch_parity_err, .i_bus_parity_err);
